// *** rtl/crt_pkg.sv ***
// constants for the crt readout port and marker dot block
// assumes one 100 MHz clock and an instrument bus sampled on that clock
package crt_pkg;
    // clock period
    localparam int CLK_NS = 10;
    // bus decode nibbles
    localparam logic [3:0] NIB_CONTROL = 4'h5;
    localparam logic [3:0] NIB_RAM_PORT = 4'h2;
    // control port fields
    localparam int CTL_ON = 0;
    localparam int CTL_ADDR_SEL = 1;
    localparam int CTL_A9 = 2;
    localparam int CTL_MAX_SPAN = 3;
    localparam int CTL_A8 = 4;
    localparam int CTL_SIXTEEN = 5;
    localparam int CTL_FORTY = 6;
    localparam int CTL_SPECTRUM = 7;
    localparam logic [7:0] CTL_RESET = 8'h00;
    // character byte fields
    localparam int CHR_CODE_W = 6;
    localparam int CHR_SKIP = 6;
    localparam int CHR_BLANK = 7;
    // screen geometry
    localparam logic [3:0] LINES_SHORT = 4'h1;
    localparam logic [3:0] LINES_LONG = 4'hf;
    localparam logic [5:0] COLS_SHORT = 6'h1f;
    localparam logic [5:0] COLS_LONG = 6'h27;
    // marker and off gap timing, nanoseconds and rounded counts
    localparam int RETRACE_NS = 5900;
    localparam int UNBLANK_NS = 5000;
    localparam int OFF_GAP_NS = 140000;
    localparam int RETRACE_CYC = (RETRACE_NS + CLK_NS / 2) / CLK_NS;
    localparam int UNBLANK_CYC = (UNBLANK_NS + CLK_NS / 2) / CLK_NS;
    localparam int OFF_GAP_CYC = (OFF_GAP_NS + CLK_NS / 2) / CLK_NS;
    // centre-screen horizontal position
    localparam logic [11:0] DOT_CENTRE = 12'h000;
    // scan states
    typedef enum logic [2:0] {
        CRT_S_OFF, CRT_S_LOAD, CRT_S_GAP, CRT_S_DRAW, CRT_S_MARKER
    } crt_scan_e;
    // marker states
    typedef enum logic [1:0] {
        CRT_M_IDLE, CRT_M_RETRACE, CRT_M_UNBLANK
    } crt_mark_e;
endpackage : crt_pkg

// *** rtl/crt_readout_port.sv ***
// crt readout port, character ram, readout scan and marker dot sequencer
// assumes bus address, data and data valid are synchronous to i_clk
module crt_readout_port
    import crt_pkg::*;
#(
    parameter int OFF_GAP_CYCLES = OFF_GAP_CYC,
    parameter int CHAR_CYCLES = 64,
    parameter int RAM_DEPTH = 1024
)
(
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic [7:0] i_bus_addr,
    input wire logic [7:0] i_bus_data,
    input wire logic i_data_valid,
    input wire logic [11:0] i_max_dot_pos,
    output logic [9:0] o_ram_addr,
    output logic [5:0] o_char_code,
    output logic o_char_generator_active,
    output logic o_readout_off,
    output logic o_readout_unblank,
    output logic o_show_marker_dot,
    output logic o_dot_interval,
    output logic o_marker_setup_low,
    output logic [11:0] o_marker_h_pos,
    output logic o_current_boost_en,
    output logic o_sixteen_line,
    output logic o_forty_char,
    output logic [3:0] o_line_cnt
);
    logic dv_r; // data valid one cycle ago
    logic [7:0] addr_r; // address held while strobe valid
    logic [7:0] data_r; // data held while strobe valid
    logic [7:0] ctl_r; // control port
    logic [7:0] host_lo_r; // latched low host address
    logic [7:0] char_r; // character under scan
    logic [7:0] ram [RAM_DEPTH]; // character memory
    logic [3:0] line_r; // scan line counter
    logic [5:0] col_r; // scan column counter
    logic [15:0] scan_cnt_r; // gap and draw timer
    logic [9:0] mark_cnt_r; // marker timer
    crt_scan_e scan_r;
    crt_mark_e mark_r;
    logic strobe_end; // falling edge of data valid
    logic wr_ctl; // control port write
    logic wr_ram_port; // address/data port write
    logic [9:0] host_addr; // full host address
    logic [9:0] scan_addr; // scan position address
    logic line_d_fall; // frame wrap, starts the dot
    logic mark_done; // last cycle of unblank
    logic [3:0] last_line;
    logic [5:0] last_col;

    // capture address and data while the strobe is valid
    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            dv_r <= 1'b0;
            addr_r <= 8'h00;
            data_r <= 8'h00;
        end
        else
        begin
            dv_r <= i_data_valid;
            if (i_data_valid)
            begin
                addr_r <= i_bus_addr;
                data_r <= i_bus_data;
            end
        end
    end

    assign strobe_end = dv_r & ~i_data_valid;
    assign wr_ctl = strobe_end & (addr_r[7:4] == NIB_CONTROL);
    assign wr_ram_port = strobe_end & (addr_r[7:4] == NIB_RAM_PORT);

    // control port register
    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            ctl_r <= CTL_RESET;
        else if (wr_ctl)
            ctl_r <= data_r;
    end

    // address byte when select set; relies on host ordering
    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            host_lo_r <= 8'h00;
        else if (wr_ram_port && ctl_r[CTL_ADDR_SEL])
            host_lo_r <= data_r;
    end

    // upper host address bits from control port
    assign host_addr = {ctl_r[CTL_A9], ctl_r[CTL_A8], host_lo_r};
    assign scan_addr = {line_r, col_r};

    // character memory: write with select clear, read during scan load
    // no reset on the array, contents are undefined until loaded
    always_ff @(posedge i_clk)
    begin
        if (wr_ram_port && !ctl_r[CTL_ADDR_SEL])
            ram[host_addr] <= data_r;
        if (scan_r == CRT_S_LOAD)
            char_r <= ram[scan_addr];
    end

    assign last_line = ctl_r[CTL_SIXTEEN] ? LINES_LONG : LINES_SHORT;
    assign last_col = ctl_r[CTL_FORTY] ? COLS_LONG : COLS_SHORT;
    // scan leaves last position of the last line
    assign line_d_fall = (scan_r == CRT_S_DRAW) && (scan_cnt_r == 16'h0000)
        && (line_r == last_line)
        && (char_r[CHR_SKIP] || col_r == last_col);

    // readout scan sequencer
    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            scan_r <= CRT_S_OFF;
            line_r <= 4'h0;
            col_r <= 6'h00;
            scan_cnt_r <= 16'h0000;
        end
        // scan stops while readout is off
        else if (!ctl_r[CTL_ON])
        begin
            scan_r <= CRT_S_OFF;
            line_r <= 4'h0;
            col_r <= 6'h00;
        end
        else
        begin
            unique case (scan_r)
                CRT_S_OFF:
                    scan_r <= CRT_S_LOAD;
                CRT_S_LOAD:
                begin
                    scan_r <= CRT_S_GAP;
                    scan_cnt_r <= ctl_r[CTL_SPECTRUM] ?
                        16'(OFF_GAP_CYCLES - 1) : 16'h0000;
                end
                CRT_S_GAP:
                    if (scan_cnt_r != 16'h0000)
                        scan_cnt_r <= scan_cnt_r - 16'h0001;
                    else
                    begin
                        scan_r <= CRT_S_DRAW;
                        scan_cnt_r <= char_r[CHR_BLANK] ?
                            16'h0000 : 16'(CHAR_CYCLES - 1);
                    end
                CRT_S_DRAW:
                    if (scan_cnt_r != 16'h0000)
                        scan_cnt_r <= scan_cnt_r - 16'h0001;
                    else
                    begin
                        // skip bit jumps to next line
                        if (char_r[CHR_SKIP] || col_r == last_col)
                        begin
                            col_r <= 6'h00;
                            line_r <= (line_r == last_line) ? 4'h0 :
                                line_r + 4'h1;
                        end
                        else
                            col_r <= col_r + 6'h01;
                        scan_r <= (line_d_fall && ctl_r[CTL_SPECTRUM]) ?
                            CRT_S_MARKER : CRT_S_LOAD;
                    end
                CRT_S_MARKER:
                    if (mark_done)
                        scan_r <= CRT_S_LOAD;
            endcase
        end
    end

    // rounded counts end the retrace and unblank phases
    assign mark_done = (mark_r == CRT_M_UNBLANK) && (mark_cnt_r == 10'h000);

    // marker dot sequencer
    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            mark_r <= CRT_M_IDLE;
            mark_cnt_r <= 10'h000;
        end
        else
        begin
            unique case (mark_r)
                CRT_M_IDLE:
                    if (line_d_fall && ctl_r[CTL_SPECTRUM] && ctl_r[CTL_ON])
                    begin
                        mark_r <= CRT_M_RETRACE;
                        mark_cnt_r <= 10'(RETRACE_CYC - 1);
                    end
                CRT_M_RETRACE:
                    if (mark_cnt_r != 10'h000)
                        mark_cnt_r <= mark_cnt_r - 10'h001;
                    else
                    begin
                        mark_r <= CRT_M_UNBLANK;
                        mark_cnt_r <= 10'(UNBLANK_CYC - 1);
                    end
                CRT_M_UNBLANK:
                    if (mark_cnt_r != 10'h000)
                        mark_cnt_r <= mark_cnt_r - 10'h001;
                    else
                        mark_r <= CRT_M_IDLE;
            endcase
        end
    end

    // registered display outputs
    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            o_ram_addr <= 10'h000;
            o_char_code <= 6'h00;
            o_char_generator_active <= 1'b0;
            o_readout_off <= 1'b0;
            o_readout_unblank <= 1'b0;
            o_show_marker_dot <= 1'b0;
            o_dot_interval <= 1'b1;
            o_marker_setup_low <= 1'b1;
            o_marker_h_pos <= DOT_CENTRE;
            o_current_boost_en <= 1'b0;
            o_sixteen_line <= 1'b0;
            o_forty_char <= 1'b0;
            o_line_cnt <= 4'h0;
        end
        else
        begin
            o_ram_addr <= ctl_r[CTL_ON] ? scan_addr : host_addr;
            o_char_code <= char_r[CHR_CODE_W-1:0];
            o_char_generator_active <= (scan_r == CRT_S_DRAW);
            // readout off low when readout owns beam
            o_readout_off <= ctl_r[CTL_SPECTRUM]
                && !(scan_r == CRT_S_DRAW && !char_r[CHR_BLANK])
                && (mark_r == CRT_M_IDLE);
            // unblank while the dot is shown
            // gated by bit7 so a sequence already running when the
            // spectrum is disabled never lights the dot
            o_readout_unblank <= (mark_r == CRT_M_UNBLANK)
                && ctl_r[CTL_SPECTRUM];
            o_show_marker_dot <= (mark_r == CRT_M_UNBLANK)
                && ctl_r[CTL_SPECTRUM];
            // dot interval low until dot drawn
            o_dot_interval <= (mark_r == CRT_M_IDLE);
            // setup low through retrace and dot
            o_marker_setup_low <= (mark_r == CRT_M_IDLE);
            o_marker_h_pos <= ctl_r[CTL_MAX_SPAN] ? i_max_dot_pos :
                DOT_CENTRE;
            o_current_boost_en <= ctl_r[CTL_SPECTRUM];
            o_sixteen_line <= ctl_r[CTL_SIXTEEN];
            o_forty_char <= ctl_r[CTL_FORTY];
            o_line_cnt <= line_r;
        end
    end
endmodule : crt_readout_port

// *** tb/crt_host_model.sv ***
// microcomputer side of the instrument bus, write cycles only
// assumes the bench calls its tasks; drives after the falling edge
module crt_host_model
(
    input wire logic i_clk,
    output logic [7:0] o_bus_addr,
    output logic [7:0] o_bus_data,
    output logic o_data_valid
);
    timeunit 1ns;
    timeprecision 1ns;
    // bus idle with strobe low from time zero
    initial
    begin
        o_bus_addr = 8'h00;
        o_bus_data = 8'h00;
        o_data_valid = 1'b0;
    end
    // strobe then release
    // released lines show the inverse so stale values never match
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_clk);
        o_bus_addr = a;
        o_bus_data = d;
        o_data_valid = 1'b1;
        @(negedge i_clk);
        o_data_valid = 1'b0;
        @(negedge i_clk);
        o_bus_addr = ~a;
        o_bus_data = ~d;
    endtask : wr
    task automatic load_char(input logic [9:0] a, input logic [7:0] d);
        logic [7:0] hi;
        hi = {3'b100, a[8], 1'b0, a[9], 2'b00};
        wr(8'h5f, hi | 8'h02);
        wr(8'h2f, a[7:0]);
        wr(8'h5f, hi);
        wr(8'h2f, d);
    endtask : load_char
endmodule : crt_host_model

// *** tb/crt_readout_port_test.sv ***
// self-checking bench for the crt readout port and marker dot
// assumes short scan counts; the host model issues all bus writes
`define CHK(nm, ex, got) begin check_count++; \
    if ((got) !== (ex)) begin \
    $display("FAIL %s exp %0h got %0h", nm, ex, got); \
    error_cnt++; end end
module crt_readout_port_test
    import crt_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    // one row: control byte, low address, then what should appear
    typedef struct packed {
        logic [7:0] ctl; logic [7:0] low; logic [9:0] addr;
        logic [2:0] mode; logic [11:0] hpos;
    } crt_row_s;
    crt_row_s rows [4];
    logic i_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic [11:0] i_max_dot_pos = 12'h5a3;
    logic [7:0] i_bus_addr, i_bus_data;
    logic i_data_valid;
    logic [9:0] o_ram_addr;
    logic [5:0] o_char_code;
    logic o_char_generator_active, o_readout_off, o_readout_unblank;
    logic o_show_marker_dot, o_dot_interval, o_marker_setup_low;
    logic [11:0] o_marker_h_pos;
    logic o_current_boost_en, o_sixteen_line, o_forty_char;
    logic [3:0] o_line_cnt;
    // mode flags gathered so one compare covers them
    logic [2:0] mode_now;
    assign mode_now = {o_sixteen_line, o_forty_char, o_current_boost_en};
    // cycles seen drawing the skipping character
    int gen_n;
    int error_cnt = 0;
    int check_count = 0;
    int cyc = 0;
    int n, low_n;
    always #5 i_clk = ~i_clk;
    // short gap and draw counts keep the whole scan near 1820 cycles, marker dot included
    localparam int TB_GAP_CYCLES = 20;
    localparam int TB_CHAR_CYCLES = 4;
    crt_readout_port #(
        .OFF_GAP_CYCLES(TB_GAP_CYCLES),
        .CHAR_CYCLES(TB_CHAR_CYCLES)
    ) dut_u (
        .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_bus_addr(i_bus_addr),
        .i_bus_data(i_bus_data), .i_data_valid(i_data_valid),
        .i_max_dot_pos(i_max_dot_pos), .o_ram_addr(o_ram_addr),
        .o_char_code(o_char_code),
        .o_char_generator_active(o_char_generator_active),
        .o_readout_off(o_readout_off),
        .o_readout_unblank(o_readout_unblank),
        .o_show_marker_dot(o_show_marker_dot),
        .o_dot_interval(o_dot_interval),
        .o_marker_setup_low(o_marker_setup_low),
        .o_marker_h_pos(o_marker_h_pos),
        .o_current_boost_en(o_current_boost_en),
        .o_sixteen_line(o_sixteen_line), .o_forty_char(o_forty_char),
        .o_line_cnt(o_line_cnt));
    crt_host_model host_u (.i_clk(i_clk), .o_bus_addr(i_bus_addr),
        .o_bus_data(i_bus_data), .o_data_valid(i_data_valid));
    // verdict and end of run
    task automatic print_verdict();
        if (error_cnt == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : print_verdict
    // hang guard, well above the expected run length
    always @(posedge i_clk)
    begin
        cyc++;
        if (cyc == 10000)
        begin
            error_cnt++;
            print_verdict();
        end
    end
    initial
    begin
        rows = '{'{8'h02, 8'h00, 10'h000, 3'h0, 12'h000},
                 '{8'h0e, 8'h3c, 10'h23c, 3'h0, 12'h5a3},
                 '{8'h32, 8'hff, 10'h1ff, 3'h4, 12'h000},
                 '{8'hd6, 8'ha5, 10'h3a5, 3'h3, 12'h000}};
        repeat (5) @(negedge i_clk);
        `CHK("rst dot_interval", 1'b1, o_dot_interval)
        `CHK("rst readout_off", 1'b0, o_readout_off)
        i_sys_rst = 1'b0;
        // table rows: host address, mode bits and dot position
        foreach (rows[i])
        begin
            host_u.wr(8'h5f, rows[i].ctl);
            host_u.wr(8'h2f, rows[i].low);
            repeat (2) @(negedge i_clk);
            `CHK("ram_addr", rows[i].addr, o_ram_addr)
            `CHK("mode", rows[i].mode, mode_now)
            `CHK("h_pos", rows[i].hpos, o_marker_h_pos)
        end
        // unmapped nibbles leave both ports alone
        host_u.wr(8'h3f, 8'h00);
        host_u.wr(8'h7f, 8'h00);
        repeat (2) @(negedge i_clk);
        `CHK("unmapped addr", 10'h3a5, o_ram_addr)
        `CHK("unmapped mode", 1'b1, o_forty_char)
        // line 0 holds one skipping char, line 1 only blanks
        host_u.load_char(10'h000, 8'h41);
        for (int c = 0; c < 32; c++)
            host_u.load_char(10'h040 + 10'(c), 8'h80);
        host_u.wr(8'h5f, 8'h81);
        n = 0;
        gen_n = 0;
        while (o_line_cnt !== 4'h1 && n < 60)
        begin
            @(negedge i_clk);
            n++;
            if (o_char_generator_active === 1'b1 && o_char_code === 6'h01)
                gen_n++;
        end
        `CHK("char drawn", TB_CHAR_CYCLES, gen_n)
        `CHK("skip line", 4'h1, o_line_cnt)
        `CHK("scan addr", 4'h1, o_ram_addr[9:6])
        n = 0;
        low_n = 0;
        while (o_dot_interval !== 1'b0 && n < 3000)
        begin
            @(negedge i_clk);
            n++;
            if (o_readout_off !== 1'b1 && o_dot_interval === 1'b1)
                low_n++;
        end
        `CHK("blank steals", 1'b1, low_n < 2)
        `CHK("marker start", 1'b0, o_dot_interval)
        `CHK("marker off", 1'b0, o_readout_off)
        `CHK("setup low", 1'b0, o_marker_setup_low)
        n = 0;
        while (o_show_marker_dot !== 1'b1 && n < 2000)
        begin
            @(negedge i_clk);
            n++;
        end
        `CHK("retrace", RETRACE_CYC, n)
        n = 0;
        while (o_show_marker_dot === 1'b1 && n < 2000)
        begin
            @(negedge i_clk);
            n++;
        end
        `CHK("unblank", UNBLANK_CYC, n)
        `CHK("interval end", 1'b1, o_dot_interval)
        // spectrum off while scanning forces trace off
        host_u.wr(8'h5f, 8'h01);
        repeat (3) @(negedge i_clk);
        `CHK("forced", 2'h0, {o_readout_off, o_current_boost_en})
        print_verdict();
    end
endmodule : crt_readout_port_test

// *** tb/crt_readout_props.sv ***
// assertions on the outputs of the crt readout port
// assumes binding onto crt_readout_port, one clock, async reset
module crt_readout_props
    import crt_pkg::*;
#(
    parameter int OFF_GAP_CYCLES = 20,
    parameter int CHAR_CYCLES = 4
)
(
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic o_readout_off,
    input wire logic o_readout_unblank,
    input wire logic o_show_marker_dot,
    input wire logic o_dot_interval,
    input wire logic o_marker_setup_low,
    input wire logic o_current_boost_en,
    input wire logic o_sixteen_line,
    input wire logic [3:0] o_line_cnt
);
    timeunit 1ns;
    timeprecision 1ns;
    // run length of the dot pulse, so widths need no long repetition
    logic [10:0] show_cnt_r;
    // run length of the low dot interval
    logic [10:0] low_cnt_r;
    // count while the dot is shown
    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            show_cnt_r <= 11'h000;
        else
            show_cnt_r <= o_show_marker_dot ? show_cnt_r + 11'h001 : 11'h000;
    end
    // count while the interval is low
    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            low_cnt_r <= 11'h000;
        else
            low_cnt_r <= !o_dot_interval ? low_cnt_r + 11'h001 : 11'h000;
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    a_boost_off_low: assert property (
        !o_current_boost_en |-> !o_readout_off)
        else $error("readout off high with spectrum disabled");
    a_no_dot_off: assert property (
        !o_current_boost_en |-> !o_show_marker_dot)
        else $error("dot shown with spectrum disabled");
    a_interval_off_low: assert property (
        !o_dot_interval |-> !o_readout_off)
        else $error("readout off high in dot interval");
    a_setup_tracks: assert property (
        o_marker_setup_low == o_dot_interval)
        else $error("setup low differs from dot interval");
    a_unblank_show: assert property (
        o_readout_unblank == o_show_marker_dot)
        else $error("unblank differs from show dot");
    a_retrace_wait: assert property (
        $rose(o_show_marker_dot) |-> low_cnt_r == RETRACE_CYC)
        else $error("retrace delay wrong");
    a_unblank_width: assert property (
        $fell(o_show_marker_dot) |-> show_cnt_r == UNBLANK_CYC)
        else $error("unblank width wrong");
    a_interval_hold: assert property (
        $rose(o_dot_interval) |-> $past(o_show_marker_dot)
        && low_cnt_r == RETRACE_CYC + UNBLANK_CYC)
        else $error("dot interval ended early or late");
    a_two_lines: assert property (
        !o_sixteen_line |-> o_line_cnt <= 4'h1)
        else $error("line count beyond two line mode");
endmodule : crt_readout_props

bind crt_readout_port crt_readout_props #(
    .OFF_GAP_CYCLES(OFF_GAP_CYCLES),
    .CHAR_CYCLES(CHAR_CYCLES)
) chk_u (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .o_readout_off(o_readout_off),
    .o_readout_unblank(o_readout_unblank),
    .o_show_marker_dot(o_show_marker_dot),
    .o_dot_interval(o_dot_interval),
    .o_marker_setup_low(o_marker_setup_low),
    .o_current_boost_en(o_current_boost_en),
    .o_sixteen_line(o_sixteen_line),
    .o_line_cnt(o_line_cnt)
);
